// File: dv/card_uart_pin_control_assertions.sv
// Concurrent checks on the card UART pin-control ports
module card_uart_pin_control_assertions (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [1:0] host_addr_hi,
  input wire logic       host_addr_bit_zero,
  input wire logic       even_byte_enable_n,
  input wire logic       odd_byte_enable_n,
  input wire logic       host_wr,
  input wire logic       host_rd,
  input wire logic [7:0] host_wdata_low,
  input wire logic [7:0] host_data_lane_low,
  input wire logic [7:0] host_data_lane_high,
  input wire logic       arb_clock_in,
  input wire logic [1:0] arb_divisor_select,
  input wire logic       arb_clock_out,
  input wire logic       uart_reset,
  input wire logic       cts_n,
  input wire logic       dsr_n,
  input wire logic       dcd_n,
  input wire logic       dtr_n,
  input wire logic       modem_irq,
  input wire logic       depth_select,
  input wire logic [6:0] fifo_depth,
  input wire logic       fifo_extended
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ctl_wr;
  logic msr_rd;
  assign ctl_wr = host_wr && !even_byte_enable_n && !host_addr_bit_zero && host_addr_hi == 2'h2
                  && !uart_reset;
  assign msr_rd = host_rd && !even_byte_enable_n && !host_addr_bit_zero && host_addr_hi == 2'h3;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence quiet_lines;
    ($stable(cts_n) && $stable(dsr_n) && $stable(dcd_n)) [*6];
  endsequence
  sequence depth_high;
    depth_select [*4];
  endsequence
  chk_idle_lanes: assert property (!host_rd
    |=> {host_data_lane_high, host_data_lane_low} == 0) else $error("read lanes not idle");
  chk_no_enable: assert property (host_rd && even_byte_enable_n && odd_byte_enable_n
    |=> {host_data_lane_high, host_data_lane_low} == 0) else $error("read without enable");
  chk_odd_only: assert property (host_rd && even_byte_enable_n && !odd_byte_enable_n
    |=> host_data_lane_low == 8'h00) else $error("odd read on low lanes");
  chk_even_only: assert property (host_rd && !even_byte_enable_n && odd_byte_enable_n
    |=> host_data_lane_high == 8'h00) else $error("even read on high lanes");
  chk_dtr_on: assert property (ctl_wr && host_wdata_low[0] && !host_wdata_low[4]
    |-> ##2 !dtr_n) else $error("terminal ready not active");
  chk_dtr_off: assert property (ctl_wr && (!host_wdata_low[0] || host_wdata_low[4])
    |-> ##2 dtr_n) else $error("terminal ready not inactive");
  chk_dtr_hold: assert property (!$past(host_wr) && !$past(host_wr, 2) && !uart_reset
    && !$past(uart_reset) |-> $stable(dtr_n)) else $error("terminal ready moved alone");
  chk_irq_clear: assert property (quiet_lines ##0 msr_rd |-> ##3 !modem_irq)
    else $error("interrupt kept after status read");
  chk_depth_norm: assert property (depth_high |=> fifo_depth == 7'h10 && !fifo_extended)
    else $error("depth not sixteen");
  chk_depth_pair: assert property (fifo_depth == (fifo_extended ? 7'h40 : 7'h10))
    else $error("depth and extend disagree");
  chk_arb_undiv: assert property ((arb_divisor_select == 2'h0) [*6]
    |-> arb_clock_out == $past(arb_clock_in, 3)) else $error("undivided clock wrong");
endmodule

bind card_uart_pin_control card_uart_pin_control_assertions card_uart_pin_control_assertions_i (
  .clk, .rst, .host_addr_hi, .host_addr_bit_zero, .even_byte_enable_n, .odd_byte_enable_n,
  .host_wr, .host_rd, .host_wdata_low, .host_data_lane_low, .host_data_lane_high,
  .arb_clock_in, .arb_divisor_select, .arb_clock_out, .uart_reset, .cts_n, .dsr_n, .dcd_n,
  .dtr_n, .modem_irq, .depth_select, .fifo_depth, .fifo_extended
);

// File: dv/card_uart_pin_control_test.sv
// Self-checking bench for the card UART pin-control block
module card_uart_pin_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst, host_addr_bit_zero, even_byte_enable_n, odd_byte_enable_n;
  logic       host_wr, host_rd, arb_clock_in, arb_clock_out, card_reset_in, uart_reset;
  logic       uart_ref_clock, baud_clock_out_n, cts_n, dsr_n, dcd_n, dtr_n, rts_n;
  logic       modem_irq, depth_select, fifo_extended, sub_style_zbus, addr_strobe_in;
  logic       sub_select_n, sub_rd_n, sub_wr_n, sub_ad_oe;
  logic [1:0] host_addr_hi, arb_divisor_select;
  logic [2:0] line_req_n;
  logic [6:0] rx_fifo_level, fifo_depth;
  logic [7:0] host_wdata_low, host_wdata_high, host_data_lane_low, host_data_lane_high;
  logic [7:0] sub_ad_in, sub_ad_out, ad_drv, lvl;
  int         err_total, samples_checked, cnt;
  // The shared pins carry the device's data while it drives them
  assign sub_ad_in = sub_ad_oe ? sub_ad_out : ad_drv;
  card_uart_pin_control card_uart_pin_control_i (
    .clk, .rst, .host_addr_hi, .host_addr_bit_zero, .even_byte_enable_n, .odd_byte_enable_n,
    .host_wr, .host_rd, .host_wdata_low, .host_wdata_high, .host_data_lane_low,
    .host_data_lane_high, .arb_clock_in, .arb_divisor_select, .arb_clock_out, .card_reset_in,
    .uart_reset, .uart_ref_clock, .baud_clock_out_n, .cts_n, .dsr_n, .dcd_n, .dtr_n, .rts_n,
    .modem_irq, .depth_select, .rx_fifo_level, .fifo_depth, .fifo_extended, .sub_style_zbus,
    .addr_strobe_in, .sub_select_n, .sub_rd_n, .sub_wr_n, .sub_ad_in, .sub_ad_out, .sub_ad_oe
  );
  far_side_model far_side_model_i (
    .clk, .line_req_n, .arb_clock_in, .uart_ref_clock, .cts_n, .dsr_n, .dcd_n
  );
  always #2.5 clk = !clk;
  task automatic conclude;
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic hreq(input logic w, input logic [2:0] a, input logic [1:0] en_n,
                      input logic [7:0] dl, input logic [7:0] dh);
    @(posedge clk);
    {host_addr_hi, host_addr_bit_zero} <= a;
    {odd_byte_enable_n, even_byte_enable_n} <= en_n;
    host_wdata_low <= dl;
    host_wdata_high <= dh;
    host_wr <= w;
    host_rd <= !w;
    @(posedge clk);
    {host_wr, host_rd} <= 2'h0;
    {odd_byte_enable_n, even_byte_enable_n} <= 2'h3;
    #1;
  endtask
  task automatic hrd(input logic [2:0] a, input logic [1:0] en_n, input logic [7:0] el, eh);
    hreq(1'b0, a, en_n, 8'h00, 8'h00);
    chk(host_data_lane_low, el);
    chk(host_data_lane_high, eh);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    hreq(1'b1, a, 2'h2, d, 8'h00);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    hrd(a, 2'h2, e, 8'h00);
  endtask
  // Counts rising arbitration-clock edges or falling baud edges
  task automatic count(input int n, input logic arb);
    logic p, s;
    cnt = 0;
    p = arb ? arb_clock_out : !baud_clock_out_n;
    repeat (n) begin
      cyc(1);
      s = arb ? arb_clock_out : !baud_clock_out_n;
      if (s && !p) cnt++;
      p = s;
    end
  endtask
  task automatic near(input int e);
    chk(8'((cnt >= e - 1 && cnt <= e + 1) ? e : cnt), 8'(e));
  endtask
  initial begin
    #100000;
    err_total++;
    conclude();
  end
  initial begin
    {clk, host_wr, host_rd, card_reset_in, addr_strobe_in, sub_style_zbus} = '0;
    {host_addr_hi, host_addr_bit_zero, arb_divisor_select, rx_fifo_level} = '0;
    {host_wdata_low, host_wdata_high, ad_drv, err_total, samples_checked} = '0;
    {even_byte_enable_n, odd_byte_enable_n, depth_select, sub_select_n} = 4'hf;
    {sub_rd_n, sub_wr_n, line_req_n, rst} = 6'h3f;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk({dtr_n, rts_n, baud_clock_out_n, modem_irq, fifo_depth[6:4], fifo_extended},
        8'he2);
    rd(3'h7, 8'h00);
    wr(3'h7, 8'h5a);
    rd(3'h7, 8'h5a);
    hreq(1'b1, 3'h6, 2'h0, 8'hff, 8'ha5);
    hrd(3'h6, 2'h0, 8'h00, 8'ha5);
    hrd(3'h6, 2'h1, 8'h00, 8'ha5);
    hrd(3'h7, 2'h3, 8'h00, 8'h00);
    wr(3'h4, 8'h13);
    cyc(2);
    chk({6'h0, dtr_n, rts_n}, 8'h03);
    wr(3'h4, 8'h02);
    cyc(2);
    chk({6'h0, dtr_n, rts_n}, 8'h02);
    wr(3'h2, 8'h08);
    lvl = 8'h00;
    for (int i = 0; i < 3; i++) begin
      line_req_n[i] <= 1'b0;
      cyc(10);
      chk({7'h0, modem_irq}, 8'h01);
      lvl = lvl | (8'h10 << (i == 2 ? 3 : i));
      rd(3'h6, lvl | (8'h01 << (i == 2 ? 3 : i)));
      rd(3'h6, lvl);
      cyc(2);
      chk({7'h0, modem_irq}, 8'h00);
    end
    wr(3'h2, 8'h00);
    line_req_n <= 3'h7;
    cyc(10);
    chk({7'h0, modem_irq}, 8'h00);
    rd(3'h6, 8'h0b);
    depth_select <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      wr(3'h3, m ? 8'h10 : 8'h30);
      rx_fifo_level <= m ? 7'h0d : 7'h37;
      cyc(6);
      chk({1'b0, fifo_depth}, m ? 8'h10 : 8'h40);
      chk({7'h0, rts_n}, 8'h00);
      rx_fifo_level <= rx_fifo_level + 7'h01;
      cyc(3);
      chk({7'h0, rts_n}, 8'h01);
      rd(3'h5, m ? 8'h06 : 8'h07);
    end
    depth_select <= 1'b1;
    rx_fifo_level <= 7'h3c;
    cyc(6);
    chk({rts_n, fifo_depth}, 8'h10);
    for (int c = 0; c < 4; c++) begin
      arb_divisor_select <= 2'(c);
      cyc(40);
      count(512, 1'b1);
      near(64 >> c);
    end
    wr(3'h0, 8'h04);
    cyc(40);
    count(640, 1'b0);
    near(16);
    wr(3'h0, 8'h00);
    cyc(40);
    count(200, 1'b0);
    chk(8'(cnt), 8'h00);
    wr(3'h4, 8'h01);
    // A pulse spanning at most two arbitration edges must not validate
    card_reset_in <= 1'b1;
    cyc(12);
    card_reset_in <= 1'b0;
    cyc(20);
    chk({6'h0, uart_reset, dtr_n}, 8'h00);
    card_reset_in <= 1'b1;
    cyc(60);
    chk({6'h0, uart_reset, dtr_n}, 8'h03);
    card_reset_in <= 1'b0;
    cyc(6);
    chk({7'h0, uart_reset}, 8'h00);
    wr(3'h7, 8'h3c);
    wr(3'h0, 8'hc3);
    for (int s = 0; s < 2; s++) begin
      sub_style_zbus <= s[0];
      addr_strobe_in <= !s[0];
      ad_drv <= s ? 8'h00 : 8'h07;
      cyc(4);
      addr_strobe_in <= s[0];
      ad_drv <= s ? 8'h07 : 8'h00;
      sub_rd_n <= 1'b0;
      cyc(5);
      chk({7'h0, sub_ad_oe}, 8'h00);
      sub_select_n <= 1'b0;
      cyc(5);
      chk({7'h0, sub_ad_oe}, 8'h01);
      chk(sub_ad_out, s ? 8'hc3 : 8'h3c);
      {sub_select_n, sub_rd_n} <= 2'h3;
      cyc(5);
    end
    conclude();
  end
endmodule

// File: dv/far_side_model.sv
// Far-side model: arbitration clock, UART reference clock, modem lines
module far_side_model (
  input  wire logic       clk,
  input  wire logic [2:0] line_req_n,
  output logic            arb_clock_in,
  output logic            uart_ref_clock,
  output logic            cts_n,
  output logic            dsr_n,
  output logic            dcd_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph;
  initial begin
    ph = 0;
    arb_clock_in = 1'b0;
    uart_ref_clock = 1'b0;
    {dcd_n, dsr_n, cts_n} = 3'h7;
  end
  // Both clocks run free; periods of 8 and 10 cycles keep them apart
  always @(posedge clk) begin
    ph <= ph + 1;
    {dcd_n, dsr_n, cts_n} <= line_req_n;
    if (ph % 4 == 3) arb_clock_in <= !arb_clock_in;
    if (ph % 5 == 4) uart_ref_clock <= !uart_ref_clock;
  end
endmodule

// File: hdl/card_uart_pin_control.sv
// Card UART pin control: host byte steering, clocks, modem lines, FIFO mode
//
// Local design decisions: the register offsets and the strobed register port.
module card_uart_pin_control (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] host_addr_hi,
  input  wire logic       host_addr_bit_zero,
  input  wire logic       even_byte_enable_n,
  input  wire logic       odd_byte_enable_n,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  input  wire logic [7:0] host_wdata_low,
  input  wire logic [7:0] host_wdata_high,
  output logic      [7:0] host_data_lane_low,
  output logic      [7:0] host_data_lane_high,
  input  wire logic       arb_clock_in,
  input  wire logic [1:0] arb_divisor_select,
  output logic            arb_clock_out,
  input  wire logic       card_reset_in,
  output logic            uart_reset,
  input  wire logic       uart_ref_clock,
  output logic            baud_clock_out_n,
  input  wire logic       cts_n,
  input  wire logic       dsr_n,
  input  wire logic       dcd_n,
  output logic            dtr_n,
  output logic            rts_n,
  output logic            modem_irq,
  input  wire logic       depth_select,
  input  wire logic [6:0] rx_fifo_level,
  output logic      [6:0] fifo_depth,
  output logic            fifo_extended,
  input  wire logic       sub_style_zbus,
  input  wire logic       addr_strobe_in,
  input  wire logic       sub_select_n,
  input  wire logic       sub_rd_n,
  input  wire logic       sub_wr_n,
  input  wire logic [7:0] sub_ad_in,
  output logic      [7:0] sub_ad_out,
  output logic            sub_ad_oe
);

  // Every input except the host bus and rx_fifo_level passes two flip-flops; the third stage feeds edge detection
  logic [card_uart_pkg::ASYNC_W-1:0] sync1_ff;
  logic [card_uart_pkg::ASYNC_W-1:0] sync2_ff;
  logic [1:0]                        sync3_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_ff <= {card_uart_pkg::ASYNC_W{1'b1}};
      sync2_ff <= {card_uart_pkg::ASYNC_W{1'b1}};
      sync3_ff <= 2'h3;
    end else begin
      sync1_ff <= {arb_clock_in, uart_ref_clock, cts_n, dsr_n, dcd_n, depth_select,
                   card_reset_in, sub_style_zbus, addr_strobe_in, sub_select_n,
                   sub_rd_n, sub_wr_n, arb_divisor_select, sub_ad_in};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff[card_uart_pkg::ASYNC_W-1 -: 2];
    end
  end

  logic       s_arb;
  logic       s_ref;
  logic       s_cts_n;
  logic       s_dsr_n;
  logic       s_dcd_n;
  logic       s_depth;
  logic       s_card_rst;
  logic       s_zbus;
  logic       s_strobe;
  logic       s_sel_n;
  logic       s_rd_n;
  logic       s_wr_n;
  logic [1:0] s_div_sel;
  logic [7:0] s_ad;
  logic       arb_rise;
  logic       ref_rise;

  assign {s_arb, s_ref, s_cts_n, s_dsr_n, s_dcd_n, s_depth, s_card_rst, s_zbus,
          s_strobe, s_sel_n, s_rd_n, s_wr_n, s_div_sel, s_ad} = sync2_ff;
  assign arb_rise = s_arb & ~sync3_ff[1];
  assign ref_rise = s_ref & ~sync3_ff[0];

  // Arbitration clock divider
  pow2_clock_divider arb_div (
    .clk        (clk),
    .rst        (rst),
    .src_level  (s_arb),
    .src_rise   (arb_rise),
    .div_select (s_div_sel),
    .div_out    (arb_clock_out)
  );

  // Card reset counts undivided arbitration clock edges before it takes effect
  logic [3:0] rstv_cnt_ff;
  logic [3:0] nxt_rstv_cnt;
  logic       uart_rst_ff;
  logic       nxt_uart_rst;

  always_comb begin
    nxt_rstv_cnt = rstv_cnt_ff;
    if (!s_card_rst) begin
      nxt_rstv_cnt = 4'h0;
    end else if (arb_rise && rstv_cnt_ff != card_uart_pkg::RESET_VALID_EDGES) begin
      nxt_rstv_cnt = rstv_cnt_ff + 4'h1;
    end
    nxt_uart_rst = (nxt_rstv_cnt == card_uart_pkg::RESET_VALID_EDGES);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rstv_cnt_ff <= 4'h0;
      uart_rst_ff <= 1'b0;
    end else begin
      rstv_cnt_ff <= nxt_rstv_cnt;
      uart_rst_ff <= nxt_uart_rst;
    end
  end

  logic regs_rst;
  assign regs_rst   = rst | uart_rst_ff;
  assign uart_reset = uart_rst_ff;

  // Host byte steering
  logic       even_sel;
  logic       odd_sel;
  logic       low_valid;
  logic       high_valid;
  logic [2:0] low_off;
  logic [2:0] high_off;

  always_comb begin
    even_sel   = ~even_byte_enable_n;
    odd_sel    = ~odd_byte_enable_n;
    low_valid  = 1'b0;
    high_valid = 1'b0;
    low_off    = {host_addr_hi, 1'b0};
    high_off   = {host_addr_hi, 1'b1};
    if (even_sel && odd_sel) begin
      low_valid  = 1'b1;
      high_valid = 1'b1;
    end else if (even_sel) begin
      low_valid = 1'b1;
      low_off   = {host_addr_hi, host_addr_bit_zero};
    end else if (odd_sel) begin
      high_valid = 1'b1;
    end
  end

  // Register file
  logic [7:0] regs_ff [8];
  logic [7:0] nxt_regs [8];
  logic [7:0] msr_val;
  logic [7:0] mode_val;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      nxt_regs[i] = regs_ff[i];
    end
    if (host_wr && low_valid && card_uart_pkg::WRITABLE_MASK[low_off]) begin
      nxt_regs[low_off] = host_wdata_low;
    end
    if (host_wr && high_valid && card_uart_pkg::WRITABLE_MASK[high_off]) begin
      nxt_regs[high_off] = host_wdata_high;
    end
  end

  always_ff @(posedge clk) begin
    if (regs_rst) begin
      for (int i = 0; i < 8; i++) begin
        regs_ff[i] <= card_uart_pkg::REG_RESET;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        regs_ff[i] <= nxt_regs[i];
      end
    end
  end

  function automatic logic [7:0] read_reg(input logic [2:0] off, input logic [7:0] modem_status_reg,
                                          input logic [7:0] mode, input logic [7:0] cur);
    logic [7:0] val;
    val = cur;
    if (off == card_uart_pkg::OFF_MODEM_STAT) begin
      val = modem_status_reg;
    end else if (off == card_uart_pkg::OFF_MODE_STAT) begin
      val = mode;
    end
    return val;
  endfunction

  // Modem status lines
  logic msr_read;
  logic cts_act;
  logic dsr_act;
  logic dcd_act;
  logic cts_chg;
  logic dsr_chg;
  logic dcd_chg;

  assign msr_read = host_rd &&
                    ((low_valid && low_off == card_uart_pkg::OFF_MODEM_STAT) ||
                     (high_valid && high_off == card_uart_pkg::OFF_MODEM_STAT));

  modem_line_tracker cts_trk (
    .clk         (clk),
    .rst         (regs_rst),
    .line_n      (s_cts_n),
    .status_read (msr_read),
    .active      (cts_act),
    .changed     (cts_chg)
  );

  modem_line_tracker dsr_trk (
    .clk         (clk),
    .rst         (regs_rst),
    .line_n      (s_dsr_n),
    .status_read (msr_read),
    .active      (dsr_act),
    .changed     (dsr_chg)
  );

  modem_line_tracker dcd_trk (
    .clk         (clk),
    .rst         (regs_rst),
    .line_n      (s_dcd_n),
    .status_read (msr_read),
    .active      (dcd_act),
    .changed     (dcd_chg)
  );

  always_comb begin
    msr_val = 8'h00;
    msr_val[card_uart_pkg::MSR_CTS_BIT]  = cts_act;
    msr_val[card_uart_pkg::MSR_DCTS_BIT] = cts_chg;
    msr_val[card_uart_pkg::MSR_DSR_BIT]  = dsr_act;
    msr_val[card_uart_pkg::MSR_DDSR_BIT] = dsr_chg;
    msr_val[card_uart_pkg::MSR_DCD_BIT]  = dcd_act;
    msr_val[card_uart_pkg::MSR_DDCD_BIT] = dcd_chg;
  end

  // FIFO mode, modem control outputs and interrupt
  logic [7:0] fifo_control_reg;
  logic [7:0] modem_control_reg;
  logic       ext_mode;
  logic       auto_rts;
  logic       rts_stop;
  logic [6:0] nxt_depth;
  logic       nxt_dtr_n;
  logic       nxt_rts_n;
  logic       nxt_irq;
  logic [6:0] depth_ff;
  logic       ext_ff;
  logic       dtr_n_ff;
  logic       rts_n_ff;
  logic       irq_ff;

  always_comb begin
    fifo_control_reg      = regs_ff[card_uart_pkg::OFF_FIFO_CTL];
    modem_control_reg      = regs_ff[card_uart_pkg::OFF_MODEM_CTL];
    ext_mode = ~s_depth & fifo_control_reg[card_uart_pkg::FCR_EXTEND_BIT];
    nxt_depth = ext_mode ? card_uart_pkg::DEPTH_EXTENDED
                         : card_uart_pkg::DEPTH_NORMAL;
    auto_rts = ~s_depth & fifo_control_reg[card_uart_pkg::FCR_AUTO_RTS];
    rts_stop = auto_rts && (rx_fifo_level >= (ext_mode ? card_uart_pkg::RTS_STOP_EXTENDED
                                              : card_uart_pkg::RTS_STOP_NORMAL));
    // Loopback keeps both modem outputs off the line
    nxt_dtr_n = ~(modem_control_reg[card_uart_pkg::MCR_DTR_BIT] &
                  ~modem_control_reg[card_uart_pkg::MCR_LOOP_BIT]);
    nxt_rts_n = ~(modem_control_reg[card_uart_pkg::MCR_RTS_BIT] & ~modem_control_reg[card_uart_pkg::MCR_LOOP_BIT] &
                  ~rts_stop);
    nxt_irq = regs_ff[card_uart_pkg::OFF_INT_EN][card_uart_pkg::IER_MODEM_BIT] &
              (cts_chg | dsr_chg | dcd_chg);
    mode_val = {5'h00, rts_stop, auto_rts, ext_mode};
  end

  always_ff @(posedge clk) begin
    if (regs_rst) begin
      depth_ff <= card_uart_pkg::DEPTH_NORMAL;
      ext_ff   <= 1'b0;
      dtr_n_ff <= 1'b1;
      rts_n_ff <= 1'b1;
      irq_ff   <= 1'b0;
    end else begin
      depth_ff <= nxt_depth;
      ext_ff   <= ext_mode;
      dtr_n_ff <= nxt_dtr_n;
      rts_n_ff <= nxt_rts_n;
      irq_ff   <= nxt_irq;
    end
  end

  assign fifo_depth    = depth_ff;
  assign fifo_extended = ext_ff;
  assign dtr_n         = dtr_n_ff;
  assign rts_n         = rts_n_ff;
  assign modem_irq     = irq_ff;

  // Baud clock: one reference period low per divisor count of reference edges
  logic [15:0] baud_div;
  logic [15:0] baud_cnt_ff;
  logic [15:0] nxt_baud_cnt;
  logic        baud_n_ff;
  logic        nxt_baud_n;

  always_comb begin
    baud_div     = {regs_ff[card_uart_pkg::OFF_BAUD_HIGH], regs_ff[card_uart_pkg::OFF_BAUD_LOW]};
    nxt_baud_cnt = baud_cnt_ff;
    nxt_baud_n   = baud_n_ff;
    if (baud_div == 16'h0000) begin
      nxt_baud_cnt = 16'h0000;
      nxt_baud_n   = 1'b1;
    end else if (ref_rise) begin
      if (baud_cnt_ff <= 16'h0001) begin
        nxt_baud_cnt = baud_div;
        nxt_baud_n   = 1'b0;
      end else begin
        nxt_baud_cnt = baud_cnt_ff - 16'h0001;
        nxt_baud_n   = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (regs_rst) begin
      baud_cnt_ff <= 16'h0000;
      baud_n_ff   <= 1'b1;
    end else begin
      baud_cnt_ff <= nxt_baud_cnt;
      baud_n_ff   <= nxt_baud_n;
    end
  end

  assign baud_clock_out_n = baud_n_ff;

  // Host read data, one cycle after the strobe
  logic [7:0] hrd_low_ff;
  logic [7:0] hrd_high_ff;
  logic [7:0] nxt_hrd_low;
  logic [7:0] nxt_hrd_high;

  always_comb begin
    nxt_hrd_low  = 8'h00;
    nxt_hrd_high = 8'h00;
    if (host_rd && low_valid) begin
      nxt_hrd_low = read_reg(low_off, msr_val, mode_val, regs_ff[low_off]);
    end
    if (host_rd && high_valid) begin
      nxt_hrd_high = read_reg(high_off, msr_val, mode_val, regs_ff[high_off]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hrd_low_ff  <= 8'h00;
      hrd_high_ff <= 8'h00;
    end else begin
      hrd_low_ff  <= nxt_hrd_low;
      hrd_high_ff <= nxt_hrd_high;
    end
  end

  assign host_data_lane_low  = hrd_low_ff;
  assign host_data_lane_high = hrd_high_ff;

  // Subsystem read-only view; its reads leave the change flags alone
  logic [7:0] sub_addr_ff;
  logic [7:0] nxt_sub_addr;
  logic [7:0] sub_out_ff;
  logic [7:0] nxt_sub_out;
  logic       sub_oe_ff;
  logic       nxt_sub_oe;
  logic       strobe_act;
  logic       sub_read;

  always_comb begin
    strobe_act   = s_zbus ? ~s_strobe : s_strobe;
    nxt_sub_addr = strobe_act ? s_ad : sub_addr_ff;
    sub_read     = ~s_sel_n & ~s_rd_n & (~s_zbus | s_wr_n);
    nxt_sub_oe   = sub_read;
    nxt_sub_out  = sub_read ? read_reg(sub_addr_ff[2:0], msr_val, mode_val,
                                       regs_ff[sub_addr_ff[2:0]]) : 8'h00;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sub_addr_ff <= 8'h00;
      sub_out_ff  <= 8'h00;
      sub_oe_ff   <= 1'b0;
    end else begin
      sub_addr_ff <= nxt_sub_addr;
      sub_out_ff  <= nxt_sub_out;
      sub_oe_ff   <= nxt_sub_oe;
    end
  end

  assign sub_ad_out = sub_out_ff;
  assign sub_ad_oe  = sub_oe_ff;

endmodule

// File: hdl/card_uart_pkg.sv
// Constants shared by the card UART pin-control block
package card_uart_pkg;

  // Register offsets, one byte each, host and subsystem alike
  localparam logic [2:0] OFF_BAUD_LOW  = 3'h0;
  localparam logic [2:0] OFF_BAUD_HIGH = 3'h1;
  localparam logic [2:0] OFF_INT_EN    = 3'h2;
  localparam logic [2:0] OFF_FIFO_CTL  = 3'h3;
  localparam logic [2:0] OFF_MODEM_CTL = 3'h4;
  localparam logic [2:0] OFF_MODE_STAT = 3'h5;
  localparam logic [2:0] OFF_MODEM_STAT = 3'h6;
  localparam logic [2:0] OFF_SCRATCH   = 3'h7;

  // Offsets that software may write; the rest are read-only
  localparam logic [7:0] WRITABLE_MASK = 8'h9f;
  localparam logic [7:0] REG_RESET     = 8'h00;

  // Field positions
  localparam int IER_MODEM_BIT   = 3;
  localparam int FCR_AUTO_RTS    = 4;
  localparam int FCR_EXTEND_BIT  = 5;
  localparam int MCR_DTR_BIT     = 0;
  localparam int MCR_RTS_BIT     = 1;
  localparam int MCR_LOOP_BIT    = 4;
  localparam int MSR_DCTS_BIT    = 0;
  localparam int MSR_DDSR_BIT    = 1;
  localparam int MSR_DDCD_BIT    = 3;
  localparam int MSR_CTS_BIT     = 4;
  localparam int MSR_DSR_BIT     = 5;
  localparam int MSR_DCD_BIT     = 7;

  // FIFO depths and auto request-to-send thresholds
  localparam logic [6:0] DEPTH_NORMAL   = 7'h10;
  localparam logic [6:0] DEPTH_EXTENDED = 7'h40;
  localparam logic [6:0] RTS_STOP_NORMAL   = 7'h0e;
  localparam logic [6:0] RTS_STOP_EXTENDED = 7'h38;

  // Rising edges of the arbitration clock that validate a card reset
  localparam logic [3:0] RESET_VALID_EDGES = 4'h4;

  // Synchroniser vector width
  localparam int ASYNC_W = 22;

endpackage

// File: hdl/modem_line_tracker.sv
// Tracks one active-low modem status line: level and sticky change flag
module modem_line_tracker (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic line_n,
  input  wire logic status_read,
  output logic      active,
  output logic      changed
);

  logic prev_ff;
  logic nxt_prev;
  logic delta_ff;
  logic nxt_delta;

  always_comb begin
    nxt_prev = line_n;
    // A change in the very cycle of the read survives the clear
    nxt_delta = (line_n != prev_ff) | (delta_ff & ~status_read);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_ff  <= 1'b1;
      delta_ff <= 1'b0;
    end else begin
      prev_ff  <= nxt_prev;
      delta_ff <= nxt_delta;
    end
  end

  assign active  = ~prev_ff;
  assign changed = delta_ff;

endmodule

// File: hdl/pow2_clock_divider.sv
// Divides a sampled clock level by 1, 2, 4 or 8
module pow2_clock_divider (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       src_level,
  input  wire logic       src_rise,
  input  wire logic [1:0] div_select,
  output logic            div_out
);

  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic       out_ff;
  logic       nxt_out;

  always_comb begin
    nxt_cnt = src_rise ? cnt_ff + 3'h1 : cnt_ff;
    // Code 0 passes the input, codes 1..3 pick a counter bit
    unique case (div_select)
      2'h0: nxt_out = src_level;
      2'h1: nxt_out = nxt_cnt[0];
      2'h2: nxt_out = nxt_cnt[1];
      2'h3: nxt_out = nxt_cnt[2];
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 3'h0;
      out_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
    end
  end

  assign div_out = out_ff;

endmodule
